// File: src/rtt_map.vh
// register indices, field positions, reset values and counts of the tamper block
`ifndef RTT_MAP_VH
`define RTT_MAP_VH

// register indices (byte address = 4 * index)
`define RTT_IDX_TIME_SECONDS  6'h00
`define RTT_IDX_TIME_MINUTES  6'h01
`define RTT_IDX_TIME_HOURS    6'h02
`define RTT_IDX_DATE_DAY      6'h04
`define RTT_IDX_DATE_MONTH    6'h05
`define RTT_IDX_DATE_YEAR     6'h06
`define RTT_IDX_CONTROL_ONE   6'h08
`define RTT_IDX_CONTROL_TWO   6'h09
`define RTT_IDX_CONTROL_THREE 6'h0A
`define RTT_IDX_CAL_HIGH      6'h2A
`define RTT_IDX_CAL_LOW       6'h2B
`define RTT_IDX_TAMPER_CTL1   6'h2C
`define RTT_IDX_TAMPER_CTL2   6'h2D
`define RTT_IDX_TAMPER_STAT   6'h2E

// power-on reset values
`define RTT_RST_CAL_HIGH      8'h00
`define RTT_RST_CAL_LOW       8'h00
`define RTT_RST_TAMPER_CTL1   8'h00
`define RTT_RST_TAMPER_CTL2   8'h00

// calibration high fields
`define RTT_CAL_ADD_PULSE_BIT 7
`define RTT_CAL_EIGHT_BIT     6
`define RTT_CAL_SIXTEEN_BIT   5
`define RTT_CAL_MINUS_MSB_BIT 0
`define RTT_CAL_HIGH_MASK     8'hE1

// tamper control one fields
`define RTT_T1_POL3_BIT       6
`define RTT_T1_EN3_BIT        5
`define RTT_T1_POL2_BIT       4
`define RTT_T1_EN2_BIT        3
`define RTT_T1_POL1_BIT       2
`define RTT_T1_EN1_BIT        1
`define RTT_T1_IRQ_EN_BIT     0
`define RTT_T1_MASK           8'h7F

// tamper control two fields
`define RTT_T2_PU_DIS_BIT     7
`define RTT_T2_PRCH_HI        6
`define RTT_T2_PRCH_LO        5
`define RTT_T2_FLT_HI         4
`define RTT_T2_FLT_LO         3
`define RTT_T2_FREQ_HI        2
`define RTT_T2_FREQ_LO        0

// calibration window and add-pulse spacing, as powers of two of kernel clock pulses
`define RTT_CAL_WINDOW_BITS   20
`define RTT_ADD_PULSE_BITS    11

// slowest sampling divisor is 2^15
`define RTT_SAMPLE_DIV_BITS   15

// bus answers
`define RTT_RESP_OKAY         2'h0
`define RTT_RESP_SLVERR       2'h2

`endif

// File: src/rtt_tamper_cal.v
// tamper detection and smooth calibration count of the real-time clock
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rtt_map.vh"

module rtt_tamper_cal (
  // clock and resets
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire        sys_rst_n_i,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp_o,
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  // status from neighbouring rtc logic
  input  wire        wr_unlocked_i,
  input  wire        recal_pending_flag_i,
  // tamper pins and their weak pull-ups
  input  wire        tamper_pin_one_i,
  input  wire        tamper_pin_two_i,
  input  wire        tamper_pin_three_i,
  output wire [2:0]  pullup_en_o,
  // calendar pulse trimming and interrupt
  output wire        cal_mask_pulse_o,
  output wire        cal_add_pulse_o,
  output wire        tamper_irq_o
);

  // registers kept across system reset
  reg  [7:0]  cal_high_reg;      // add pulse, period bits, minus msb
  reg  [7:0]  cal_low_reg;       // minus count low byte
  reg  [7:0]  tamper_ctl1_reg;   // polarity, enable, irq enable
  reg  [7:0]  tamper_ctl2_reg;   // precharge, filter, rate
  reg  [2:0]  tamper_flag_reg;   // sticky detection flags

  // bus state
  reg         awready_reg;       // address slot free
  reg         wready_reg;        // data slot free
  reg         aw_full_reg;       // address captured
  reg         w_full_reg;        // data captured
  reg  [5:0]  aw_idx_reg;        // captured write index
  reg  [7:0]  w_data_reg;        // captured low byte
  reg         w_lane_reg;        // low byte lane enabled
  reg         bvalid_reg;        // write answer pending
  reg  [1:0]  bresp_reg;         // write answer code
  reg         arready_reg;       // read slot free
  reg         rvalid_reg;        // read answer pending
  reg  [31:0] rdata_reg;         // read data
  reg  [1:0]  rresp_reg;         // read answer code

  // calibration state
  reg  [19:0] cal_cnt_reg;       // position in 2^20 window
  reg         cal_mask_reg;      // masks this kernel pulse
  reg         cal_add_reg;       // inserts an extra pulse

  // tamper sampling state
  reg  [14:0] div_cnt_reg;       // free-running sample divider
  reg  [2:0]  pullup_reg;        // weak pull-up drive
  reg  [3:0]  run_cnt_reg [0:2]; // consecutive active samples
  reg         irq_reg;           // registered interrupt request

  // combinational helpers
  wire        wr_fire;           // captured write performed now
  wire        wr_hit;            // write index is mapped
  wire        wr_allow;          // protection and byte lane let write through
  wire [8:0]  cal_minus_count;   // effective 9-bit minus count
  wire [14:0] div_mask;          // divisor minus one
  wire [14:0] phase;             // position inside sample period
  wire [3:0]  pre_len;           // precharge length in cycles
  wire        sample_tick;       // sample taken this cycle
  wire        precharge_on;      // pull-up phase active
  wire [3:0]  need_cnt;          // samples needed for an event
  wire [2:0]  pin_level;         // pins as sampled
  wire [2:0]  pin_pol;           // per-input active level
  wire [2:0]  pin_en;            // per-input enable
  reg  [2:0]  event_now;         // detection this cycle
  reg  [3:0]  run_next [0:2];    // next run counts
  integer     i;                 // loop index

  // power of two from a small code: 1, 2, 4, 8
  function [3:0] rtt_pow2;
    input [1:0] code;
    begin
      rtt_pow2 = 4'h1 << code;
    end
  endfunction

  // register index mapped in this block
  function rtt_mapped;
    input [5:0] idx;
    begin
      rtt_mapped = (idx == `RTT_IDX_CAL_HIGH) || (idx == `RTT_IDX_CAL_LOW) ||
                   (idx == `RTT_IDX_TAMPER_CTL1) || (idx == `RTT_IDX_TAMPER_CTL2) ||
                   (idx == `RTT_IDX_TAMPER_STAT);
    end
  endfunction

  // output ports straight from flops
  assign s_axi_awready_o  = awready_reg;
  assign s_axi_wready_o   = wready_reg;
  assign s_axi_bvalid_o   = bvalid_reg;
  assign s_axi_bresp_o    = bresp_reg;
  assign s_axi_arready_o  = arready_reg;
  assign s_axi_rvalid_o   = rvalid_reg;
  assign s_axi_rdata_o    = rdata_reg;
  assign s_axi_rresp_o    = rresp_reg;
  assign pullup_en_o      = pullup_reg;
  assign cal_mask_pulse_o = cal_mask_reg;
  assign cal_add_pulse_o  = cal_add_reg;
  assign tamper_irq_o     = irq_reg;

  // write happens once address and data are both held
  assign wr_fire  = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_hit   = rtt_mapped(aw_idx_reg);
  assign wr_allow = wr_unlocked_i & w_lane_reg;

  // effective minus count with forced low bits
  // the period bits clear the low count bits, so a short period
  // never masks a count that its window cannot hold evenly
  assign cal_minus_count = {cal_high_reg[`RTT_CAL_MINUS_MSB_BIT],
    cal_low_reg[7:2],
    cal_low_reg[1] & ~cal_high_reg[`RTT_CAL_EIGHT_BIT],
    cal_low_reg[0] & ~cal_high_reg[`RTT_CAL_EIGHT_BIT]
                   & ~cal_high_reg[`RTT_CAL_SIXTEEN_BIT]};

  // shared sampling settings, one set for all inputs
  assign div_mask = 15'h7FFF >> tamper_ctl2_reg[`RTT_T2_FREQ_HI:`RTT_T2_FREQ_LO];
  assign phase    = div_cnt_reg & div_mask;
  assign sample_tick = (phase == div_mask);
  assign pre_len  = rtt_pow2(tamper_ctl2_reg[`RTT_T2_PRCH_HI:`RTT_T2_PRCH_LO]);
  assign precharge_on = ~tamper_ctl2_reg[`RTT_T2_PU_DIS_BIT] &
    (phase >= (div_mask - {11'h000, pre_len})) & ~sample_tick;
  assign need_cnt = rtt_pow2(tamper_ctl2_reg[`RTT_T2_FLT_HI:`RTT_T2_FLT_LO]);

  // per-input level and enable
  assign pin_level = {tamper_pin_three_i, tamper_pin_two_i, tamper_pin_one_i};
  assign pin_pol   = {tamper_ctl1_reg[`RTT_T1_POL3_BIT],
                      tamper_ctl1_reg[`RTT_T1_POL2_BIT],
                      tamper_ctl1_reg[`RTT_T1_POL1_BIT]};
  assign pin_en    = {tamper_ctl1_reg[`RTT_T1_EN3_BIT],
                      tamper_ctl1_reg[`RTT_T1_EN2_BIT],
                      tamper_ctl1_reg[`RTT_T1_EN1_BIT]};

  // run counters and detection per input
  // the count stops at the filter length, so a pin held active
  // raises one event only; a fresh run is needed for the next one
  // a disabled input is held at zero so enabling it never fires at once
  always @* begin
    event_now = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      run_next[i] = run_cnt_reg[i];
      if (!pin_en[i]) begin
        run_next[i] = 4'h0;
      end else if (sample_tick) begin
        if (pin_level[i] == pin_pol[i]) begin
          if (run_cnt_reg[i] < need_cnt) begin
            run_next[i] = run_cnt_reg[i] + 4'h1;
            event_now[i] = (run_cnt_reg[i] + 4'h1 == need_cnt);
          end
        end else begin
          run_next[i] = 4'h0;
        end
      end
    end
  end

  // write channel: capture address and data in either order
  // each slot closes on its own handshake and both reopen only after
  // the answer is taken, so one write at most is in flight
  // a write refused by protection or the byte lane still answers okay
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_idx_reg  <= 6'h00;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RTT_RESP_OKAY;
    end else begin
      // address taken
      if (awready_reg && s_axi_awvalid_i) begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_idx_reg  <= s_axi_awaddr_i[7:2];
      end
      // data taken
      if (wready_reg && s_axi_wvalid_i) begin
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata_i[7:0];
        w_lane_reg <= s_axi_wstrb_i[0];
      end
      // both held: answer
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `RTT_RESP_OKAY : `RTT_RESP_SLVERR;
      end
      // answer taken: reopen both slots
      if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // register file, cleared by power-on reset only
  // system reset leaves these alone on purpose
  // a flag clear and a new event in one cycle: the event wins, so no
  // tamper is ever lost to a late clear
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_high_reg    <= `RTT_RST_CAL_HIGH;
      cal_low_reg     <= `RTT_RST_CAL_LOW;
      tamper_ctl1_reg <= `RTT_RST_TAMPER_CTL1;
      tamper_ctl2_reg <= `RTT_RST_TAMPER_CTL2;
      tamper_flag_reg <= 3'h0;
    end else begin
      // flags: clear by writing one, a new event wins
      if (wr_fire && wr_allow && aw_idx_reg == `RTT_IDX_TAMPER_STAT) begin
        tamper_flag_reg <= (tamper_flag_reg & ~w_data_reg[2:0]) | event_now;
      end else begin
        tamper_flag_reg <= tamper_flag_reg | event_now;
      end
      if (wr_fire && wr_allow) begin
        case (aw_idx_reg)
          `RTT_IDX_CAL_HIGH: begin
            if (!recal_pending_flag_i) begin
              cal_high_reg <= w_data_reg & `RTT_CAL_HIGH_MASK;
            end
          end
          `RTT_IDX_CAL_LOW: begin
            if (!recal_pending_flag_i) begin
              cal_low_reg <= w_data_reg;
            end
          end
          `RTT_IDX_TAMPER_CTL1: begin
            tamper_ctl1_reg <= w_data_reg & `RTT_T1_MASK;
          end
          `RTT_IDX_TAMPER_CTL2: begin
            tamper_ctl2_reg <= w_data_reg;
          end
          default: begin
            cal_low_reg <= cal_low_reg;
          end
        endcase
      end
    end
  end

  // read channel: one cycle from address to data
  // data are taken in the cycle of the address handshake and then
  // stand until the master takes them
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `RTT_RESP_OKAY;
    end else begin
      if (arready_reg && s_axi_arvalid_i) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rresp_reg   <= rtt_mapped(s_axi_araddr_i[7:2]) ? `RTT_RESP_OKAY
                                                       : `RTT_RESP_SLVERR;
        case (s_axi_araddr_i[7:2])
          `RTT_IDX_CAL_HIGH:    rdata_reg <= {24'h000000, cal_high_reg};
          `RTT_IDX_CAL_LOW:     rdata_reg <= {24'h000000, cal_low_reg};
          `RTT_IDX_TAMPER_CTL1: rdata_reg <= {24'h000000, tamper_ctl1_reg};
          `RTT_IDX_TAMPER_CTL2: rdata_reg <= {24'h000000, tamper_ctl2_reg};
          `RTT_IDX_TAMPER_STAT: rdata_reg <= {29'h0000000, tamper_flag_reg};
          default:              rdata_reg <= 32'h00000000;
        endcase
      end
      // answer taken: accept next read
      if (rvalid_reg && s_axi_rready_i) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // calibration window: mask the first n pulses, add one per 2^11
  // the masked pulses sit at the start of each window; the trimming
  // logic downstream drops every kernel pulse that sees the mask high
  // system reset restarts the window but keeps the count
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_cnt_reg  <= 20'h00000;
      cal_mask_reg <= 1'b0;
      cal_add_reg  <= 1'b0;
    end else if (!sys_rst_n_i) begin
      cal_cnt_reg  <= 20'h00000;
      cal_mask_reg <= 1'b0;
      cal_add_reg  <= 1'b0;
    end else begin
      cal_cnt_reg  <= cal_cnt_reg + 20'h00001;
      cal_mask_reg <= (cal_cnt_reg < {11'h000, cal_minus_count});
      cal_add_reg  <= cal_high_reg[`RTT_CAL_ADD_PULSE_BIT] &
                      (cal_cnt_reg[10:0] == 11'h7FF);
    end
  end

  // sampler: divider, pull-up drive, run counters, interrupt
  // the divider runs free; a new rate takes effect at once and may
  // shorten or stretch the period that is running
  // pull-ups are one flop late, so they still stand in the sample cycle
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg    <= 15'h0000;
      pullup_reg     <= 3'h0;
      run_cnt_reg[0] <= 4'h0;
      run_cnt_reg[1] <= 4'h0;
      run_cnt_reg[2] <= 4'h0;
      irq_reg        <= 1'b0;
    end else if (!sys_rst_n_i) begin
      div_cnt_reg    <= 15'h0000;
      pullup_reg     <= 3'h0;
      run_cnt_reg[0] <= 4'h0;
      run_cnt_reg[1] <= 4'h0;
      run_cnt_reg[2] <= 4'h0;
      irq_reg        <= 1'b0;
    end else begin
      div_cnt_reg    <= div_cnt_reg + 15'h0001;
      pullup_reg     <= {3{precharge_on}};
      run_cnt_reg[0] <= run_next[0];
      run_cnt_reg[1] <= run_next[1];
      run_cnt_reg[2] <= run_next[2];
      irq_reg        <= tamper_ctl1_reg[`RTT_T1_IRQ_EN_BIT] &
                        (|tamper_flag_reg);
    end
  end

endmodule

// File: dv/rtt_switch_model.sv
// model of the three external tamper switches on the pins
`timescale 1ns/1ps
module rtt_switch_model (
  // clock
  input  wire       sys_clk_i,
  // switch commands and pull-up state
  input  wire [2:0] drive_i,
  input  wire [2:0] level_i,
  input  wire [2:0] pullup_en_i,
  // pin levels
  output wire [2:0] pins_o
);
  reg [2:0] float_reg = 3'h2;  // changing level of a loose pin

  // a loose unpulled pin must not look settled
  always @(posedge sys_clk_i) begin
    float_reg <= ~float_reg;
  end

  // closed switch wins, else weak pull-up, else noise
  assign pins_o = (drive_i & level_i) | (~drive_i & pullup_en_i)
                | (~drive_i & ~pullup_en_i & float_reg);
endmodule

// File: dv/rtt_tamper_cal_sva.sv
// port checks of the tamper and calibration block
`timescale 1ns/1ps
module rtt_tamper_cal_sva (
  // clock and resets
  input wire        sys_clk_i,
  input wire        rst_n_i,
  input wire        sys_rst_n_i,
  // bus handshakes
  input wire        s_axi_awvalid_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_wvalid_i,
  input wire        s_axi_wready_o,
  input wire [1:0]  s_axi_bresp_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  // pins and pulses
  input wire [2:0]  pullup_en_o,
  input wire        cal_mask_pulse_o,
  input wire        cal_add_pulse_o,
  input wire        tamper_irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // address and data taken
  sequence s_aw_taken;
    s_axi_awvalid_i && s_axi_awready_o;
  endsequence
  sequence s_w_taken;
    s_axi_wvalid_i && s_axi_wready_o;
  endsequence

  chk_aw_closed: assert property (s_aw_taken |=> !s_axi_awready_o)
    else $error("awready stayed high after address taken");
  chk_b_answer: assert property (s_aw_taken and s_w_taken |=> ##[0:1] s_axi_bvalid_o)
    else $error("write not answered in time");
  chk_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped early");
  chk_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    !s_axi_bvalid_o && s_axi_awready_o)
    else $error("write answer not released");
  chk_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered next cycle");
  chk_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data changed while waiting");
  chk_pullup_shared: assert property (pullup_en_o == 3'h0 || pullup_en_o == 3'h7)
    else $error("pull-ups differ between pins");
  chk_add_single: assert property ($rose(cal_add_pulse_o) |=> !cal_add_pulse_o [*8])
    else $error("add pulse longer than one cycle");
  chk_sys_reset: assert property (!sys_rst_n_i |=>
    !tamper_irq_o && pullup_en_o == 3'h0 && !cal_mask_pulse_o)
    else $error("system reset left outputs active");
endmodule

bind rtt_tamper_cal rtt_tamper_cal_sva CHK (.sys_clk_i, .rst_n_i, .sys_rst_n_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .pullup_en_o, .cal_mask_pulse_o, .cal_add_pulse_o,
  .tamper_irq_o);

// File: dv/rtt_tamper_cal_bench.sv
// self-checking bench of the tamper and calibration block
`timescale 1ns/1ps
`include "rtt_map.vh"
module rtt_tamper_cal_bench;
  localparam [5:0] cal_hi = `RTT_IDX_CAL_HIGH;
  localparam [5:0] cal_lo = `RTT_IDX_CAL_LOW;
  localparam [5:0] ctl1   = `RTT_IDX_TAMPER_CTL1;
  localparam [5:0] ctl2   = `RTT_IDX_TAMPER_CTL2;
  localparam [5:0] stat   = `RTT_IDX_TAMPER_STAT;
  reg         sys_clk_i, rst_n_i, sys_rst_n_i;           // clock and resets
  reg  [7:0]  awaddr, araddr;                            // bus drive
  reg  [31:0] wdata;
  reg         awvalid, wvalid, bready, arvalid, rready;
  reg         unlocked, pending;                         // neighbour status
  reg  [2:0]  drv, lvl;                                  // switch commands
  reg  [3:0]  wstrb;                                     // write byte lanes
  wire        awready, wready, bvalid, arready, rvalid, mask_p, add_p, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  pu, pins;
  integer     mismatches, samples_checked, i, n, k;
  reg  [31:0] seed;
  reg  [7:0]  mdl [0:63];                                // register model

  rtt_tamper_cal DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sys_rst_n_i(sys_rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .wr_unlocked_i(unlocked),
    .recal_pending_flag_i(pending), .tamper_pin_one_i(pins[0]), .tamper_pin_two_i(pins[1]),
    .tamper_pin_three_i(pins[2]), .pullup_en_o(pu), .cal_mask_pulse_o(mask_p),
    .cal_add_pulse_o(add_p), .tamper_irq_o(irq));
  rtt_switch_model SW (.sys_clk_i(sys_clk_i), .drive_i(drv), .level_i(lvl),
    .pullup_en_i(pu), .pins_o(pins));

  // next pseudo-random word
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // index served by this block
  function mapped(input [5:0] a);
    mapped = (a >= cal_hi) && (a <= stat);
  endfunction
  // compare and count one result
  task chk(input string nm, input [31:0] e, input [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus write, model follows the access rules
  task wr(input [5:0] a, input [7:0] d);
    awaddr <= {a, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    while (n == 0) begin
      @(posedge sys_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk("bresp", mapped(a) ? `RTT_RESP_OKAY : `RTT_RESP_SLVERR, bresp);
        n = 1;
      end
    end
    if (mapped(a) && unlocked && wstrb[0] && a != stat && !(pending && a <= cal_lo))
      mdl[a] = (a == ctl1) ? d & `RTT_T1_MASK :
               (a == cal_hi) ? d & `RTT_CAL_HIGH_MASK : d;
  endtask
  // one bus read against an expected word
  task rd(input [5:0] a, input [31:0] e);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    n = 0;
    while (n == 0) begin
      @(posedge sys_clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk("rdata", e, rdata);
        chk("rresp", mapped(a) ? `RTT_RESP_OKAY : `RTT_RESP_SLVERR, rresp);
        n = 1;
      end
    end
  endtask
  // pull-up cycles in one period of the fastest rate
  task pu_count;
    @(posedge sys_clk_i); // let the new setting reach the pull-ups
    n = 0;
    while (pu[0] !== 1'b1 && n < 600) begin
      @(posedge sys_clk_i);
      n = n + 1;
    end
    k = 0;
    repeat (256) begin
      if (pu[0] === 1'b1) k = k + 1;
      @(posedge sys_clk_i);
    end
  endtask
  // masked run at the start of a window freshly restarted by system reset
  task mask_count;
    sys_rst_n_i <= 1'b0;
    @(posedge sys_clk_i);
    sys_rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    n = 0;
    while (mask_p !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      n = n + 1;
    end
    k = 0;
    while (mask_p === 1'b1 && k < 600) begin
      @(posedge sys_clk_i);
      k = k + 1;
    end
  endtask
  // verdict and end of run
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // 40 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // watchdog against a hang
  initial begin
    #(25.0 * 40000);
    mismatches = mismatches + 1;
    end_of_test;
  end
  // main sequence
  initial begin
    {rst_n_i, awaddr, araddr, wdata, awvalid, wvalid, arvalid, unlocked, pending} = 0;
    {sys_rst_n_i, bready, rready, drv, lvl} = {3'h7, 3'h7, 3'h6};
    {mismatches, samples_checked} = 0;
    seed = 32'h373437D4;
    wstrb = 4'hF;
    for (i = 0; i < 64; i = i + 1) mdl[i] = 8'h00;
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (i = 42; i < 47; i = i + 1) rd(i, mdl[i]);
    rd(`RTT_IDX_TIME_SECONDS, 0);
    wr(ctl1, 8'hFF);
    rd(ctl1, mdl[ctl1]);
    unlocked <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      wr(cal_lo, seed[7:0]);
      rd(cal_lo, mdl[cal_lo]);
    end
    wr(ctl1, 8'hFF);
    rd(ctl1, mdl[ctl1]);
    wstrb <= 4'hE;
    wr(ctl2, 8'h5A);
    rd(ctl2, mdl[ctl2]);
    wstrb <= 4'hF;
    pending <= 1'b1;
    wr(cal_lo, ~mdl[cal_lo]);
    rd(cal_lo, mdl[cal_lo]);
    pending <= 1'b0;
    sys_rst_n_i <= 1'b0;
    @(posedge sys_clk_i);
    sys_rst_n_i <= 1'b1;
    rd(ctl1, mdl[ctl1]);
    rd(cal_lo, mdl[cal_lo]);
    // masked pulses per window, with and without the short periods
    seed = lfsr(seed);
    wr(cal_lo, seed[7:0]);
    wr(cal_hi, 8'h01);
    mask_count;
    chk("mask run", {23'h000000, 1'b1, seed[7:0]}, k);
    wr(cal_hi, 8'h40);
    mask_count;
    chk("mask run 8s", {24'h000000, seed[7:2], 2'b00}, k);
    wr(cal_hi, 8'h3F);
    rd(cal_hi, mdl[cal_hi]);
    mask_count;
    chk("mask run 16s", {23'h000000, 1'b1, seed[7:1], 1'b0}, k);
    // enabled inputs idle, disabled one active
    wr(ctl1, 8'h36);
    wr(cal_hi, 8'h80);
    n = 0;
    while (add_p !== 1'b1 && n < 5000) begin
      @(posedge sys_clk_i);
      n = n + 1;
    end
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n = n + 1;
    end while (add_p !== 1'b1 && n < 5000);
    chk("add gap", 2048, n);
    wr(cal_hi, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(ctl2, {1'b0, i[1:0], 5'h07});
      pu_count;
      chk("precharge", 1 << i, k);
    end
    wr(ctl2, 8'h87);
    pu_count;
    chk("precharge off", 0, k);
    rd(stat, 0);
    // input one turns active, filter of two samples
    wr(ctl2, 8'h8F);
    wr(ctl1, 8'h37);
    lvl[0] <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 1200) begin
      @(posedge sys_clk_i);
      n = n + 1;
    end
    chk("irq delay", 1, n > 258 && n < 1200);
    rd(stat, 1);
    lvl[0] <= 1'b0;
    repeat (600) @(posedge sys_clk_i);
    chk("irq held", 1, irq);
    wr(stat, 8'h01);
    repeat (3) @(posedge sys_clk_i);
    chk("irq cleared", 0, irq);
    wr(ctl1, 8'h36);
    lvl[0] <= 1'b1;
    repeat (800) @(posedge sys_clk_i);
    chk("irq masked", 0, irq);
    rd(stat, 1);
    end_of_test;
  end
endmodule
